// ==== verilog/cbc_bus_ctrl.sv ====
`timescale 1ns/1ps
`include "cbc_defs.svh"
// Notes on behaviour
// - qualifiers memory/io, data/control, write/read valid with the address strobe
// - lock asserts when the first locked cycle begins, maybe after its strobe
// - lock drops when acknowledge ends the last locked cycle
// - qualifier codes per cycle kind; halt and shutdown use fixed addresses
// - io control write code never shown with the strobe asserted
// - writes copy upper lanes onto lower lanes for upper-only patterns
// - strobe only in the first state and in a second state that shows the next address early
// - acknowledge on reads captures data and ends the cycle
// - acknowledge on writes ends the cycle
// - acknowledge ignored in first state, sampled each later state
// - next-address request with a pending request drives next address early, unless the current cycle spans both halves
// - half width confines the cycle to the lower sixteen lines
// - half width moves upper bytes across the lower sixteen lines
// - operand on both halves with half width gets an extra cycle
// - byte enable n maps to data lines 8n to 8n+7
// - writes, halt and shutdown drive all thirty-two data lines
// - coprocessor traffic is io cycles at the top of the address space
module cbc_bus_ctrl (
    input wire logic clk, // 10 MHz bus state clock
    input wire logic resetn, // async reset, active low
    input wire logic ce, // clock enable, freezes all state
    input wire logic req_valid, // core has a cycle to run
    input cbc_pkg::cbc_req_s req, // cycle to run
    output logic req_taken, // one-cycle pulse, request consumed
    output logic cyc_done, // one-cycle pulse, cycle finished
    output logic [31:0] rd_data, // read data, valid with cyc_done
    output logic address_strobe_n, // address strobe
    output logic mem_io, // high memory, low io
    output logic data_ctrl, // high data, low control
    output logic write_read, // high write, low read
    output logic lock_n, // atomic sequence flag
    output logic [29:0] word_address, // word address
    output logic [3:0] byte_lane_enable_n, // byte enables
    output logic [31:0] data_out, // data lines out
    output logic data_oe, // data lines driven
    input wire logic [31:0] data_in, // data lines in
    input wire logic ready_n, // transfer acknowledge
    input wire logic next_address_request_n, // pipelining request
    input wire logic half_width_bus_n // sixteen-bit bus this cycle
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [2:0] qual(input cbc_pkg::cbc_kind_e k);
        // order is {mem_io, data_ctrl, write_read}; io control write has no kind
        case (k)
            cbc_pkg::CBC_IACK: qual = 3'h0;
            cbc_pkg::CBC_IO_RD: qual = 3'h2;
            cbc_pkg::CBC_IO_WR: qual = 3'h3;
            cbc_pkg::CBC_CODE_RD: qual = 3'h4;
            cbc_pkg::CBC_MEM_RD: qual = 3'h6;
            cbc_pkg::CBC_MEM_WR: qual = 3'h7;
            default: qual = 3'h5;
        endcase
    endfunction

    function automatic logic drives(input cbc_pkg::cbc_kind_e k);
        drives = k == cbc_pkg::CBC_IO_WR || k == cbc_pkg::CBC_MEM_WR
            || k == cbc_pkg::CBC_HALT || k == cbc_pkg::CBC_SHUTDOWN;
    endfunction

    function automatic logic spans(input logic [3:0] be_n);
        spans = (be_n[1:0] != 2'h3) && (be_n[3:2] != 2'h3);
    endfunction

    function automatic logic [31:0] dup(input logic [31:0] d, input logic [3:0] be_n);
        dup = d; // lanes stay in place otherwise
        case (be_n)
            4'hb: dup[7:0] = d[23:16];
            4'h7: dup[15:8] = d[31:24];
            4'h3: dup[15:0] = d[31:16];
            default: dup = d;
        endcase
    endfunction

    function automatic cbc_pkg::cbc_req_s fix(input cbc_pkg::cbc_req_s r);
        fix = r;
        if (r.kind == cbc_pkg::CBC_HALT)
        begin
            fix.wa = `CBC_WA_SPECIAL;
            fix.be_n = `CBC_BE_N_HALT;
        end
        else if (r.kind == cbc_pkg::CBC_SHUTDOWN)
        begin
            fix.wa = `CBC_WA_SPECIAL;
            fix.be_n = `CBC_BE_N_SHUTDOWN;
        end
    endfunction

    function automatic cbc_pkg::cbc_bus_s addr(input cbc_pkg::cbc_bus_s b, input cbc_pkg::cbc_req_s r);
        addr = b;
        {addr.mio, addr.dc, addr.wr} = qual(r.kind);
        addr.wa = r.wa;
        addr.be_n = r.be_n;
        addr.ads_n = 1'b0;
    endfunction

    // start a cycle; a pipelined cycle already showed its address and strobe
    function automatic cbc_pkg::cbc_state_s begin_cyc(input cbc_pkg::cbc_state_s s,
        input cbc_pkg::cbc_req_s r, input logic strobe);
        begin_cyc = s;
        begin_cyc.cur = r;
        if (strobe)
            begin_cyc.bus = addr(s.bus, r);
        begin_cyc.dout = dup(r.data, r.be_n);
        begin_cyc.doe = drives(r.kind);
        begin_cyc.st = cbc_pkg::CBC_T1;
        if (r.lock)
            begin_cyc.bus.lock_n = 1'b0;
    endfunction

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    cbc_pkg::cbc_state_s s_reg;
    cbc_pkg::cbc_state_s s_next;
    logic take;

    // taken is registered, so a request seen in the taken cycle is stale
    assign take = req_valid && !s_reg.taken;

    always_comb
    begin
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.taken = 1'b0;
        s_next.bus.ads_n = 1'b1;
        case (s_reg.st)
            cbc_pkg::CBC_IDLE:
            begin
                if (take)
                begin
                    s_next = begin_cyc(s_next, fix(req), 1'b1);
                    s_next.taken = 1'b1;
                end
            end
            cbc_pkg::CBC_T1:
            begin
                s_next.st = cbc_pkg::CBC_T2;
            end
            default:
            begin
                if (!ready_n)
                begin
                    if (!drives(s_reg.cur.kind))
                    begin
                        // upper bytes arrive on the low half of a narrow bus
                        if (!half_width_bus_n && s_reg.cur.be_n[1:0] == 2'h3)
                            s_next.rdata[31:16] = data_in[15:0];
                        else
                            for (int i = 0; i < 4; i++)
                                if (!s_reg.cur.be_n[i])
                                    s_next.rdata[i*8 +: 8] = data_in[i*8 +: 8];
                    end
                    if (!half_width_bus_n && spans(s_reg.cur.be_n))
                    begin
                        // lower half done; rerun for the upper bytes only
                        s_next.cur.be_n = s_reg.cur.be_n | `CBC_BE_N_LOW_OFF;
                        s_next = begin_cyc(s_next, s_next.cur, 1'b1);
                    end
                    else
                    begin
                        s_next.done = 1'b1;
                        s_next.doe = 1'b0;
                        s_next.st = cbc_pkg::CBC_IDLE;
                        if (s_reg.cur.lock && s_reg.cur.lock_last)
                            s_next.bus.lock_n = 1'b1;
                        if (s_reg.nxt_v)
                        begin
                            s_next.nxt_v = 1'b0;
                            s_next = begin_cyc(s_next, s_reg.nxt, 1'b0);
                        end
                        else if (take)
                        begin
                            s_next = begin_cyc(s_next, fix(req), 1'b1);
                            s_next.taken = 1'b1;
                        end
                    end
                end
                // no pipelining when a narrow bus could still split the cycle
                else if (!next_address_request_n && take && !s_reg.nxt_v && !spans(s_reg.cur.be_n))
                begin
                    s_next.nxt = fix(req);
                    s_next.nxt_v = 1'b1;
                    s_next.taken = 1'b1;
                    s_next.bus = addr(s_reg.bus, fix(req));
                end
            end
        endcase
    end

    // state register; ce low freezes everything
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_reg <= '0;
            s_reg.bus.ads_n <= `CBC_ADS_N_RESET;
            s_reg.bus.lock_n <= `CBC_LOCK_N_RESET;
            {s_reg.bus.mio, s_reg.bus.dc, s_reg.bus.wr} <= `CBC_QUAL_RESET;
            s_reg.bus.wa <= `CBC_WA_RESET;
            s_reg.bus.be_n <= `CBC_BE_N_RESET;
        end
        else if (ce)
            s_reg <= s_next;
    end

    // ----------------------------------------------------------------
    // outputs, all straight from the state register
    // ----------------------------------------------------------------
    assign req_taken = s_reg.taken;
    assign cyc_done = s_reg.done;
    assign rd_data = s_reg.rdata;
    assign address_strobe_n = s_reg.bus.ads_n;
    assign mem_io = s_reg.bus.mio;
    assign data_ctrl = s_reg.bus.dc;
    assign write_read = s_reg.bus.wr;
    assign lock_n = s_reg.bus.lock_n;
    assign word_address = s_reg.bus.wa;
    assign byte_lane_enable_n = s_reg.bus.be_n;
    assign data_out = s_reg.dout;
    assign data_oe = s_reg.doe;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_term;
        s_reg.st == cbc_pkg::CBC_T2 && !ready_n && ce;
    endsequence

    sequence s_wait;
        s_reg.st == cbc_pkg::CBC_T2 && ready_n && next_address_request_n && ce;
    endsequence

    AST_NEVER_CODE: assert property (@(posedge clk) disable iff (!resetn)
        !address_strobe_n |-> {mem_io, data_ctrl, write_read} != `CBC_QUAL_NEVER)
        else $error("io control write shown with strobe");
    AST_FIRST_IGNORED: assert property (@(posedge clk) disable iff (!resetn)
        (s_reg.st == cbc_pkg::CBC_T1 && ce) |=> s_reg.st == cbc_pkg::CBC_T2 && !cyc_done)
        else $error("acknowledge taken in first state");
    AST_HOLD: assert property (@(posedge clk) disable iff (!resetn)
        s_wait |=> $stable(word_address) && $stable(byte_lane_enable_n) && $stable(mem_io))
        else $error("address changed while waiting");
    AST_DONE_CAUSE: assert property (@(posedge clk) disable iff (!resetn)
        cyc_done |-> $past(s_reg.st) == cbc_pkg::CBC_T2 && !$past(ready_n))
        else $error("cycle ended without acknowledge");
    AST_END: assert property (@(posedge clk) disable iff (!resetn)
        s_term ##1 (s_reg.st == cbc_pkg::CBC_IDLE) |-> cyc_done && !data_oe)
        else $error("acknowledged cycle did not end");
    AST_SPECIAL: assert property (@(posedge clk) disable iff (!resetn)
        (!address_strobe_n && {mem_io, data_ctrl, write_read} == 3'h5)
        |-> word_address == `CBC_WA_SPECIAL
        && (byte_lane_enable_n == `CBC_BE_N_HALT || byte_lane_enable_n == `CBC_BE_N_SHUTDOWN))
        else $error("halt or shutdown address wrong");
    AST_DUP: assert property (@(posedge clk) disable iff (!resetn)
        (data_oe && s_reg.cur.be_n == 4'hb) |-> data_out[7:0] == data_out[23:16])
        else $error("lane two not copied to lane zero");
    AST_STROBE_ONCE: assert property (@(posedge clk) disable iff (!resetn)
        (!address_strobe_n && ce) |=> address_strobe_n)
        else $error("strobe held two states");
    AST_LOCK_START: assert property (@(posedge clk) disable iff (!resetn)
        $fell(lock_n) |-> s_reg.st == cbc_pkg::CBC_T1 && s_reg.cur.lock)
        else $error("lock asserted outside a cycle start");
    AST_DRIVE_ALL: assert property (@(posedge clk) disable iff (!resetn)
        (s_reg.st != cbc_pkg::CBC_IDLE && drives(s_reg.cur.kind)) |-> data_oe)
        else $error("write data not driven");

endmodule

// ==== verilog/cbc_defs.svh ====
`ifndef CBC_DEFS_SVH
`define CBC_DEFS_SVH

// ----------------------------------------------------------------
// bus pin values while idle after reset
// ----------------------------------------------------------------
`define CBC_ADS_N_RESET 1'h1
`define CBC_LOCK_N_RESET 1'h1
`define CBC_QUAL_RESET 3'h2
`define CBC_BE_N_RESET 4'h0
`define CBC_WA_RESET 30'h3fff_ffff

// ----------------------------------------------------------------
// fixed encodings
// ----------------------------------------------------------------
`define CBC_QUAL_NEVER 3'h1
`define CBC_BE_N_HALT 4'hb
`define CBC_BE_N_SHUTDOWN 4'he
`define CBC_WA_SPECIAL 30'h0000_0000
`define CBC_BE_N_LOW_OFF 4'h3

`endif

// ==== verilog/cbc_pkg.sv ====
package cbc_pkg;

    // ----------------------------------------------------------------
    // cycle kinds and sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        CBC_IACK = 3'b000,
        CBC_IO_RD = 3'b001,
        CBC_IO_WR = 3'b010,
        CBC_CODE_RD = 3'b011,
        CBC_MEM_RD = 3'b100,
        CBC_MEM_WR = 3'b101,
        CBC_HALT = 3'b110,
        CBC_SHUTDOWN = 3'b111
    } cbc_kind_e;

    typedef enum logic [1:0] {
        CBC_IDLE = 2'b00,
        CBC_T1 = 2'b01,
        CBC_T2 = 2'b10
    } cbc_state_e;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        cbc_kind_e kind;
        logic [29:0] wa;
        logic [3:0] be_n;
        logic [31:0] data;
        logic lock;
        logic lock_last;
    } cbc_req_s;

    typedef struct packed {
        logic ads_n;
        logic mio;
        logic dc;
        logic wr;
        logic lock_n;
        logic [29:0] wa;
        logic [3:0] be_n;
    } cbc_bus_s;

    typedef struct packed {
        cbc_state_e st;
        cbc_bus_s bus;
        logic [31:0] dout;
        logic doe;
        cbc_req_s cur;
        cbc_req_s nxt;
        logic nxt_v;
        logic [31:0] rdata;
        logic done;
        logic taken;
    } cbc_state_s;

endpackage

// ==== tb/cbc_far_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// far side decode logic answering every bus cycle
// ----------------------------------------------------------------
module cbc_far_model (
    input wire logic clk, // bus clock
    input wire logic resetn, // async reset
    input wire logic [1:0] wt, // wait states
    input wire logic ack_all, // acknowledge held low always
    input wire logic half_en, // answer as a 16-bit port
    input wire logic pipe_en, // ask for pipelining
    input wire logic address_strobe_n, // strobe
    input wire logic mem_io, // memory or io
    input wire logic [29:0] word_address, // address
    input wire logic [3:0] byte_lane_enable_n, // enables
    output logic ready_n, // acknowledge
    output logic next_address_request_n, // next address
    output logic half_width_bus_n, // half width
    output logic [31:0] data_in // read lines
);
    logic busy_reg;
    logic queued_reg;
    logic first_reg;
    logic tick_reg;
    logic [1:0] cnt_reg;
    logic [31:0] word;
    // read value mixes the address so the bench can predict it
    assign word = {2'h0, word_address} ^ 32'h5a5a_a5a5;
    assign ready_n = !(ack_all || (busy_reg && cnt_reg == wt));
    assign next_address_request_n = !(pipe_en && busy_reg);
    // coprocessor cycles always move full words
    assign half_width_bus_n = !(half_en && (mem_io || !word_address[29]));
    // idle lines toggle so stale data never passes for an answer
    assign data_in = ready_n ? {32{tick_reg}} ^ 32'h3c3c_c3c3 :
        (!half_width_bus_n && byte_lane_enable_n[1:0] == 2'h3) ? {~word[31:16], word[31:16]} : word;
    // a strobe seen while busy is queued and later gets a first state of its own
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            busy_reg <= 1'b0;
            queued_reg <= 1'b0;
            first_reg <= 1'b0;
            tick_reg <= 1'b0;
            cnt_reg <= 2'h0;
        end
        else
        begin
            tick_reg <= !tick_reg;
            cnt_reg <= cnt_reg + 2'h1;
            if (busy_reg && !ready_n)
            begin
                busy_reg <= 1'b0;
                first_reg <= queued_reg || !address_strobe_n;
                queued_reg <= 1'b0;
            end
            else if (busy_reg && !address_strobe_n)
                queued_reg <= 1'b1;
            else if (!address_strobe_n || first_reg)
            begin
                busy_reg <= 1'b1;
                first_reg <= 1'b0;
                cnt_reg <= 2'h0;
            end
        end
    end
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`include "cbc_defs.svh"
// ----------------------------------------------------------------
// self-checking bench for the bus cycle controller
// ----------------------------------------------------------------
module tb_top;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic req_valid = 1'b0;
    cbc_pkg::cbc_req_s req = '0;
    logic req_taken, cyc_done, address_strobe_n, mem_io, data_ctrl, write_read, lock_n, data_oe;
    logic ready_n, next_address_request_n, half_width_bus_n, s_oe, s_lock, prev_stb;
    logic [31:0] rd_data, data_out, data_in, s_do;
    logic [29:0] word_address;
    logic [3:0] byte_lane_enable_n;
    logic [36:0] s_bus;
    logic [1:0] wt = 2'h0;
    logic ack_all = 1'b0;
    logic half_en = 1'b0;
    logic pipe_en = 1'b0;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    int strobes, lat;
    int dq[$];
    int sq[$];
    wire logic [36:0] cur_bus = {mem_io, data_ctrl, write_read, word_address, byte_lane_enable_n};
    // 10 MHz bus state clock
    initial forever #50 clk = ~clk;
    cbc_bus_ctrl u_dut (.clk, .resetn, .ce, .req_valid, .req, .req_taken, .cyc_done, .rd_data,
        .address_strobe_n, .mem_io, .data_ctrl, .write_read, .lock_n, .word_address, .byte_lane_enable_n,
        .data_out, .data_oe, .data_in, .ready_n, .next_address_request_n, .half_width_bus_n);
    cbc_far_model u_far (.clk, .resetn, .wt, .ack_all, .half_en, .pipe_en, .address_strobe_n, .mem_io,
        .word_address, .byte_lane_enable_n, .ready_n, .next_address_request_n, .half_width_bus_n, .data_in);
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // a hang counts as a failure
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            failures++;
            report_and_stop();
        end
    end
    // sample settled pins mid-cycle; definition may only move with a strobe
    always @(negedge clk)
    begin
        if (resetn !== 1'b1)
        begin
            s_bus = {`CBC_QUAL_RESET, `CBC_WA_RESET, `CBC_BE_N_RESET};
            prev_stb = 1'b1;
        end
        else if (address_strobe_n === 1'b0)
        begin
            check(prev_stb, 1'b1, "strobe over one state");
            check(cur_bus[36:34] === `CBC_QUAL_NEVER, 1'b0, "io control write strobed");
            s_bus = cur_bus;
            s_do = data_out;
            s_oe = data_oe;
            s_lock = lock_n;
            strobes++;
            lat = 0;
        end
        else
        begin
            check(cur_bus, s_bus, "definition moved without strobe");
            lat++;
        end
        prev_stb = address_strobe_n;
        if (cyc_done === 1'b1)
        begin
            dq.push_back(lat);
            sq.push_back(strobes);
        end
    end
    function automatic logic [31:0] word_of(input logic [29:0] wa);
        return {2'h0, wa} ^ 32'h5a5a_a5a5;
    endfunction
    // request is held until taken, then dropped on the next edge
    task automatic issue(input cbc_pkg::cbc_kind_e k, input logic [29:0] wa, input logic [3:0] be,
        input logic [1:0] lk);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{kind: k, wa: wa, be_n: be, data: 32'h4433_2211, lock: lk[1], lock_last: lk[0]};
        req_valid <= 1'b1;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (req_taken !== 1'b1 && n < 40);
        @(posedge clk);
        req_valid <= 1'b0;
    endtask
    task automatic settle(input int nd);
        int t;
        t = 0;
        while (dq.size() < nd && t < 60)
        begin
            @(negedge clk);
            t++;
        end
    endtask
    task automatic clr;
        strobes = 0;
        dq.delete();
        sq.delete();
    endtask
    task automatic one(input cbc_pkg::cbc_kind_e k, input logic [29:0] wa, input logic [3:0] be);
        clr();
        issue(k, wa, be, 2'h0);
        settle(1);
    endtask
    task automatic t_reset;
        check({address_strobe_n, lock_n, data_oe}, 3'b110, "idle pins after reset");
        check(cur_bus, {3'h2, 30'h3fff_ffff, 4'h0}, "idle definition after reset");
    endtask
    // every kind once, with varied wait states and one early acknowledge
    task automatic t_kinds;
        logic [2:0] q[8] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7, 3'h5, 3'h5};
        for (int i = 0; i < 8; i++)
        begin
            wt <= 2'(i % 3);
            ack_all <= (i == 4);
            one(cbc_pkg::cbc_kind_e'(i), 30'h0012_3450 + 30'(i), 4'h0);
            check(s_bus[36:34], q[i], "cycle qualifiers");
            check(dq[0], (i == 4) ? 2 : 2 + i % 3, "acknowledge timing");
            check(s_oe, q[i][0], "data lines driven");
            if (i >= 6)
                check(s_bus[33:0], {30'h0, (i == 6) ? 4'hb : 4'he}, "special address");
            else if (q[i][0])
                check(s_do, 32'h4433_2211, "write data lanes");
            else
                check(rd_data, word_of(30'h0012_3450 + 30'(i)), "read capture");
        end
        ack_all <= 1'b0;
    endtask
    task automatic t_dup;
        logic [3:0] be[3] = '{4'hb, 4'h7, 4'h3};
        logic [31:0] m[3] = '{32'h00ff_00ff, 32'hff00_ff00, 32'hffff_ffff};
        logic [31:0] e[3] = '{32'h0033_0033, 32'h4400_4400, 32'h4433_4433};
        for (int i = 0; i < 3; i++)
        begin
            one(cbc_pkg::CBC_MEM_WR, 30'h0000_0100, be[i]);
            check(s_do & m[i], e[i], "lane duplication");
        end
    endtask
    // 16-bit port: split, upper-only, lower-only, write and coprocessor access
    task automatic t_half;
        logic [3:0] be[5] = '{4'h0, 4'h3, 4'hc, 4'h3, 4'h0};
        logic [29:0] wa[5] = '{30'h0000_0200, 30'h0000_0204, 30'h0000_0208, 30'h0000_020c, 30'h2000_003e};
        int ns[5] = '{2, 1, 1, 1, 1};
        logic [31:0] k;
        half_en <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            one((i == 3) ? cbc_pkg::CBC_MEM_WR : (i == 4) ? cbc_pkg::CBC_IO_RD : cbc_pkg::CBC_MEM_RD, wa[i], be[i]);
            check(sq[0], ns[i], "bus cycles per transfer");
            k = {{8{!be[i][3]}}, {8{!be[i][2]}}, {8{!be[i][1]}}, {8{!be[i][0]}}};
            if (i != 3)
                check(rd_data & k, word_of(wa[i]) & k, "sized read data");
            if (i == 0)
                check(s_bus[3:0], 4'h3, "second part enables");
        end
        check(s_bus, {3'h2, 30'h2000_003e, 4'h0}, "coprocessor io cycle");
        half_en <= 1'b0;
    endtask
    // two reads confined to the lower half of the bus, the second pipelined behind the first
    task automatic t_pipe;
        clr();
        wt <= 2'h3;
        pipe_en <= 1'b1;
        issue(cbc_pkg::CBC_MEM_RD, 30'h0000_0300, 4'hc, 2'h0);
        issue(cbc_pkg::CBC_MEM_RD, 30'h0000_0301, 4'hc, 2'h0);
        settle(2);
        check(sq[0], 2, "next address before acknowledge");
        check(rd_data & 32'h0000_ffff, word_of(30'h0000_0301) & 32'h0000_ffff, "pipelined read data");
        pipe_en <= 1'b0;
    endtask
    // ce low freezes the sequencer, so a waiting request is not taken
    task automatic t_freeze;
        clr();
        @(posedge clk);
        ce <= 1'b0;
        req <= '{kind: cbc_pkg::CBC_MEM_RD, wa: 30'h0000_0500, be_n: 4'h0, data: 32'h0, lock: 1'b0, lock_last: 1'b0};
        req_valid <= 1'b1;
        repeat (4) @(negedge clk);
        check({req_taken, address_strobe_n}, 2'b01, "cycle started while frozen");
        @(posedge clk);
        ce <= 1'b1;
        issue(cbc_pkg::CBC_MEM_RD, 30'h0000_0500, 4'h0, 2'h0);
        settle(1);
        check(rd_data, word_of(30'h0000_0500), "read after freeze");
    endtask
    task automatic t_lock;
        clr();
        wt <= 2'h1;
        issue(cbc_pkg::CBC_MEM_RD, 30'h0000_0400, 4'h0, 2'h2);
        settle(1);
        check({s_lock, lock_n}, 2'b00, "locked flag held between cycles");
        issue(cbc_pkg::CBC_MEM_WR, 30'h0000_0400, 4'h0, 2'h3);
        settle(2);
        check(lock_n, 1'b1, "locked flag released");
    endtask
    // main sequence
    initial
    begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        t_reset();
        t_kinds();
        t_dup();
        t_half();
        t_pipe();
        t_lock();
        t_freeze();
        report_and_stop();
    end
endmodule
